// *** logic/fcd_host.sv ***
// Function
// - high-voltage ID reads select by A1:A0
// - write only with ce, we low, oe high
// - program is four writes ending data
// - auto-select entry is three writes
// - only reset leaves auto-select mode
// - after error bit, host writes reset
// - erase is six writes, chip or sector
//
// host controller for a byte-wide flash: expands one operation request
// into its command write cycles, then polls status until completion for program and erase
// latches the op fields on acceptance, so they may change while busy_o is high
module fcd_host #(
  parameter int POLL_LIMIT = 100000
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic op_valid_i,
  input wire fcd_pkg::fcd_op_t op_i,
  input wire logic [16:0] op_addr_i,
  input wire logic [7:0] op_data_i,
  input wire logic [7:0] dq_in_i,
  output logic busy_o,
  output logic done_o,
  output logic error_o,
  output logic [7:0] rdata_o,
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o,
  output logic [16:0] addr_o,
  output logic [7:0] dq_out_o,
  output logic dq_oe_o
);
  // refuse a poll limit below one
  if (POLL_LIMIT < 1) begin : g_bad_limit
    $error("fcd_host: POLL_LIMIT out of range");
  end
  typedef enum {H_IDLE, H_ISSUE, H_WAIT, H_POLL, H_POLL_WAIT,
                H_RESET, H_RESET_WAIT} fcd_host_st_t;
  fcd_host_st_t st_r;
  fcd_seq_if cyc ();
  fcd_pkg::fcd_op_t op_r;
  logic [16:0] tgt_r;
  logic [7:0] dat_r;
  logic [2:0] step_r;
  logic [2:0] last_r;
  logic [31:0] poll_r;
  logic [7:0] prev_r;
  logic first_r;
  logic req_r;
  logic wr_r;
  logic [16:0] caddr_r;
  logic [7:0] cdata_r;
  logic [16:0] step_addr;
  logic [7:0] step_data;
  // ==========================================================
  // pin driver
  fcd_pin_drv u_pin (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .cyc(cyc.slave),
    .dq_in_i(dq_in_i),
    .ce_n_o(ce_n_o),
    .oe_n_o(oe_n_o),
    .we_n_o(we_n_o),
    .addr_o(addr_o),
    .dq_out_o(dq_out_o),
    .dq_oe_o(dq_oe_o)
  );
  assign cyc.req = req_r;
  assign cyc.wr = wr_r;
  assign cyc.addr = caddr_r;
  assign cyc.wdata = cdata_r;
  // ==========================================================
  // command table: address and data of each write step
  always_comb begin
    step_addr = fcd_pkg::UNLOCK1_ADDR;
    step_data = fcd_pkg::UNLOCK1_DATA;
    case (step_r)
      3'h0: begin
        step_addr = fcd_pkg::UNLOCK1_ADDR;
        step_data = fcd_pkg::UNLOCK1_DATA;
      end
      3'h1: begin
        step_addr = fcd_pkg::UNLOCK2_ADDR;
        step_data = fcd_pkg::UNLOCK2_DATA;
      end
      3'h2: begin
        // third cycle picks the command
        step_addr = fcd_pkg::UNLOCK1_ADDR;
        case (op_r)
          fcd_pkg::FCD_OP_PROGRAM: step_data = fcd_pkg::CMD_PROGRAM;
          fcd_pkg::FCD_OP_AUTOSEL: step_data = fcd_pkg::CMD_AUTOSEL;
          default: step_data = fcd_pkg::CMD_ERASE_SETUP;
        endcase
      end
      3'h3: begin
        // program data goes to full target address
        if (op_r == fcd_pkg::FCD_OP_PROGRAM) begin
          step_addr = tgt_r;
          step_data = dat_r;
        end else begin
          step_addr = fcd_pkg::UNLOCK1_ADDR;
          step_data = fcd_pkg::UNLOCK1_DATA;
        end
      end
      3'h4: begin
        step_addr = fcd_pkg::UNLOCK2_ADDR;
        step_data = fcd_pkg::UNLOCK2_DATA;
      end
      default: begin
        // sector erase uses the full sector address
        if (op_r == fcd_pkg::FCD_OP_SECTOR_ERASE) begin
          step_addr = tgt_r;
          step_data = fcd_pkg::CMD_SECTOR_ERASE;
        end else begin
          step_addr = fcd_pkg::UNLOCK1_ADDR;
          step_data = fcd_pkg::CMD_CHIP_ERASE;
        end
      end
    endcase
  end
  // ==========================================================
  // operation sequencer
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      // device starts in array read, so no command is sent
      st_r <= H_IDLE;
      op_r <= fcd_pkg::FCD_OP_READ;
      tgt_r <= 17'h00000;
      dat_r <= 8'h00;
      step_r <= 3'h0;
      last_r <= 3'h0;
      poll_r <= 32'h00000000;
      prev_r <= 8'h00;
      first_r <= 1'b0;
      req_r <= 1'b0;
      wr_r <= 1'b0;
      caddr_r <= 17'h00000;
      cdata_r <= 8'h00;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      error_o <= 1'b0;
      rdata_o <= 8'h00;
    end else begin
      done_o <= 1'b0;
      req_r <= 1'b0;
      case (st_r)
        H_IDLE: begin
          if (op_valid_i) begin
            op_r <= op_i;
            tgt_r <= op_addr_i;
            dat_r <= op_data_i;
            busy_o <= 1'b1;
            error_o <= 1'b0;
            step_r <= 3'h0;
            case (op_i)
              fcd_pkg::FCD_OP_PROGRAM: last_r <= 3'h3;
              fcd_pkg::FCD_OP_AUTOSEL: last_r <= 3'h2;
              fcd_pkg::FCD_OP_CHIP_ERASE: last_r <= 3'h5;
              fcd_pkg::FCD_OP_SECTOR_ERASE: last_r <= 3'h5;
              default: last_r <= 3'h0;
            endcase
            // plain reads and auto-select reads need no writes
            if (op_i == fcd_pkg::FCD_OP_READ) begin
              req_r <= 1'b1;
              wr_r <= 1'b0;
              caddr_r <= op_addr_i;
              st_r <= H_POLL_WAIT;
              first_r <= 1'b0;
              poll_r <= 32'h00000000;
            end else if (op_i == fcd_pkg::FCD_OP_RESET) begin
              // reset is the only way out of auto-select
              st_r <= H_RESET;
            end else begin
              st_r <= H_ISSUE;
            end
          end
        end
        H_ISSUE: begin
          req_r <= 1'b1;
          wr_r <= 1'b1;
          caddr_r <= step_addr;
          cdata_r <= step_data;
          st_r <= H_WAIT;
        end
        H_WAIT: begin
          if (cyc.done) begin
            if (step_r == last_r) begin
              if (op_r == fcd_pkg::FCD_OP_AUTOSEL) begin
                st_r <= H_IDLE;
                busy_o <= 1'b0;
                done_o <= 1'b1;
              end else begin
                // no writes while the embedded operation runs
                first_r <= 1'b1;
                poll_r <= 32'h00000000;
                st_r <= H_POLL;
              end
            end else begin
              step_r <= step_r + 3'h1;
              st_r <= H_ISSUE;
            end
          end
        end
        H_POLL: begin
          req_r <= 1'b1;
          wr_r <= 1'b0;
          caddr_r <= tgt_r;
          st_r <= H_POLL_WAIT;
        end
        H_POLL_WAIT: begin
          if (cyc.done) begin
            prev_r <= cyc.rdata;
            rdata_o <= cyc.rdata;
            first_r <= 1'b0;
            poll_r <= poll_r + 32'h00000001;
            if (op_r == fcd_pkg::FCD_OP_READ) begin
              st_r <= H_IDLE;
              busy_o <= 1'b0;
              done_o <= 1'b1;
            end else if (!first_r && (cyc.rdata[6] == prev_r[6])) begin
              // toggle stopped: device back in array read by itself
              st_r <= H_IDLE;
              busy_o <= 1'b0;
              done_o <= 1'b1;
            end else if (cyc.rdata[fcd_pkg::ERROR_BIT] ||
                         poll_r == 32'(POLL_LIMIT)) begin
              // failure or timeout: send reset
              error_o <= 1'b1;
              st_r <= H_RESET;
            end else begin
              st_r <= H_POLL;
            end
          end
        end
        H_RESET: begin
          // reset write also aborts half-sent sequences
          req_r <= 1'b1;
          wr_r <= 1'b1;
          caddr_r <= fcd_pkg::RESET_ADDR;
          cdata_r <= fcd_pkg::CMD_RESET;
          st_r <= H_RESET_WAIT;
        end
        H_RESET_WAIT: begin
          if (cyc.done) begin
            st_r <= H_IDLE;
            busy_o <= 1'b0;
            done_o <= 1'b1;
          end
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end
endmodule

// *** logic/fcd_pkg.sv ***
// flash command host package: bus timing, command codes, unlock addresses
// assumes a byte-wide asynchronous flash on a 17-bit address bus
package fcd_pkg;
  // ==========================================================
  // widths
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  // ==========================================================
  // command addresses and data
  localparam logic [16:0] UNLOCK1_ADDR = 17'h05555;
  localparam logic [16:0] UNLOCK2_ADDR = 17'h02aaa;
  localparam logic [7:0] UNLOCK1_DATA = 8'haa;
  localparam logic [7:0] UNLOCK2_DATA = 8'h55;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_AUTOSEL = 8'h90;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_RESET = 8'hf0;
  localparam logic [16:0] RESET_ADDR = 17'h00000;
  // low address of the protection verify read
  localparam logic [7:0] PROT_LOW_ADDR = 8'h02;
  localparam logic [7:0] PROT_ON_DATA = 8'h01;
  // sector field position
  localparam int SECTOR_LSB = 14;
  // status bit that flags a failed embedded operation
  localparam int ERROR_BIT = 5;
  // ==========================================================
  // bus timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int STROBE_NS = 40;   // write strobe low time
  localparam int ACCESS_NS = 90;   // read access time
  localparam int GLITCH_NS = 5;    // strobes stay well above glitch width
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC = 2;    // address/data setup around strobe
  // ==========================================================
  // host operations
  typedef enum logic [2:0] {
    FCD_OP_READ, FCD_OP_RESET, FCD_OP_PROGRAM, FCD_OP_CHIP_ERASE,
    FCD_OP_SECTOR_ERASE, FCD_OP_AUTOSEL
  } fcd_op_t;
endpackage

// *** logic/fcd_seq_if.sv ***
// carries one bus cycle request from sequencer to the pin driver
// assumes one clock shared by both ends
interface fcd_seq_if;
  logic req;
  logic wr;
  logic [16:0] addr;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;
  modport master (output req, output wr, output addr, output wdata,
                  input done, input rdata);
  modport slave (input req, input wr, input addr, input wdata,
                 output done, output rdata);
endinterface

// *** logic/fcd_pin_drv.sv ***
// pin driver: turns one read or write request into strobe timing
// assumes the flash pins are sampled and driven on clk_i
module fcd_pin_drv (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  fcd_seq_if.slave cyc,
  input wire logic [7:0] dq_in_i,
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o,
  output logic [16:0] addr_o,
  output logic [7:0] dq_out_o,
  output logic dq_oe_o
);
  typedef enum {S_IDLE, S_SETUP, S_STROBE, S_HOLD} fcd_pin_st_t;
  fcd_pin_st_t st_r;
  logic [7:0] cnt_r;
  logic wr_r;
  logic [7:0] sync1_r, sync2_r, sync3_r;
  logic [7:0] dq_flt_r;
  // ==========================================================
  // three-stage sampler of the data pins
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync1_r <= 8'h00;
      sync2_r <= 8'h00;
      sync3_r <= 8'h00;
      dq_flt_r <= 8'h00;
    end else begin
      sync1_r <= dq_in_i;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      // a change counts once the last two stages agree
      if (sync2_r == sync3_r) begin
        dq_flt_r <= sync3_r;
      end
    end
  end
  // ==========================================================
  // strobe sequencing; write keeps oe high and ce/we low together
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r <= S_IDLE;
      cnt_r <= 8'h00;
      wr_r <= 1'b0;
      ce_n_o <= 1'b1;
      oe_n_o <= 1'b1;
      we_n_o <= 1'b1;
      addr_o <= 17'h00000;
      dq_out_o <= 8'h00;
      dq_oe_o <= 1'b0;
      cyc.done <= 1'b0;
      cyc.rdata <= 8'h00;
    end else begin
      cyc.done <= 1'b0;
      case (st_r)
        S_IDLE: begin
          if (cyc.req) begin
            wr_r <= cyc.wr;
            addr_o <= cyc.addr;
            dq_out_o <= cyc.wdata;
            dq_oe_o <= cyc.wr;
            ce_n_o <= 1'b0;
            cnt_r <= 8'(fcd_pkg::SETUP_CYC);
            st_r <= S_SETUP;
          end
        end
        S_SETUP: begin
          if (cnt_r == 8'h01) begin
            // address captured at falling we (later edge)
            we_n_o <= ~wr_r;
            oe_n_o <= wr_r;
            cnt_r <= wr_r ? 8'(fcd_pkg::STROBE_CYC)
                          : 8'(fcd_pkg::ACCESS_CYC + 2);
            st_r <= S_STROBE;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        S_STROBE: begin
          // strobe held many ns, far above glitch width
          if (cnt_r == 8'h01) begin
            if (wr_r == 1'b0) begin
              cyc.rdata <= dq_flt_r;
            end
            // we rises first so data latches there
            we_n_o <= 1'b1;
            oe_n_o <= 1'b1;
            cnt_r <= 8'(fcd_pkg::SETUP_CYC);
            st_r <= S_HOLD;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        S_HOLD: begin
          if (cnt_r == 8'h01) begin
            ce_n_o <= 1'b1;
            dq_oe_o <= 1'b0;
            cyc.done <= 1'b1;
            st_r <= S_IDLE;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end
endmodule

// *** testbench/fcd_flash_model.sv ***
// behavioural byte-wide flash: command decoder, id codes and protection
// assumes the host drives strobes and address; no clock reaches it
module fcd_flash_model #(
  parameter int OP_NS = 400,
  parameter logic [7:0] MAKER_ID = 8'h5a, // arbitrary value
  parameter logic [7:0] DEVICE_ID = 8'hc3 // arbitrary value
) (
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [16:0] addr_i,
  input wire logic [7:0] dq_i,
  input wire logic hv_i,
  input wire logic fail_i,
  output logic [7:0] dq_o,
  output logic dq_en_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:131071];
  logic [7:0] prot = 8'h00;
  logic [7:0] rd = 8'h00;
  logic [7:0] sel;
  logic [16:0] a_lat;
  logic busy = 1'b0;
  logic err = 1'b0;
  logic auto = 1'b0;
  logic tog = 1'b0;
  logic wr_act = 1'b0;
  int step = 0;
  realtime t_fall;
  event go;
  // ==========================================================
  // command sequencing
  task automatic start();
    busy = 1'b1;
    err = fail_i;
    ->go;
  endtask
  task automatic erase(input logic [7:0] s);
    for (int i = 0; i < 131072; i++)
      if (s[i >> 14] && !prot[i >> 14])
        mem[i] = 8'hff;
    start();
  endtask
  task automatic cmd(input logic [16:0] a, input logic [7:0] d);
    logic u1;
    logic u2;
    u1 = a[14:0] == 15'h5555;
    u2 = a[14:0] == 15'h2aaa;
    if (busy && !err)
      return;
    if (d == 8'hf0) begin
      busy = 1'b0;
      err = 1'b0;
      auto = 1'b0;
      step = 0;
    end else if (!auto) begin
      case (step)
        0: step = (u1 && d == 8'haa) ? 1 : 0;
        1: step = (u2 && d == 8'h55) ? 2 : 0;
        2: begin
          step = (u1 && d == 8'ha0) ? 3 : (u1 && d == 8'h80) ? 4 : 0;
          auto = u1 && d == 8'h90;
        end
        3: begin
          step = 0;
          if (!prot[a[16:14]])
            mem[a] = mem[a] & d;
          start();
        end
        4: step = (u1 && d == 8'haa) ? 5 : 0;
        5: step = (u2 && d == 8'h55) ? 6 : 0;
        default: begin
          step = 0;
          if (u1 && d == 8'h10)
            erase(8'hff);
          else if (d == 8'h30)
            erase(8'h01 << a[16:14]);
        end
      endcase
    end
  endtask
  // memory erased at power-up
  initial begin
    for (int i = 0; i < 131072; i++)
      mem[i] = 8'hff;
  end
  // embedded operation ends by itself unless it failed
  always @(go) begin
    #(OP_NS);
    if (!err)
      busy = 1'b0;
  end
  // address at the later fall, write only with oe high
  always @(negedge we_n_i or negedge ce_n_i) begin
    if (!we_n_i && !ce_n_i && oe_n_i) begin
      wr_act = 1'b1;
      t_fall = $realtime;
      a_lat = addr_i;
    end
  end
  // data at the earlier rise; short pulses are dropped
  always @(posedge we_n_i or posedge ce_n_i) begin
    if (wr_act) begin
      wr_act = 1'b0;
      if (oe_n_i && $realtime - t_fall >= 5.0)
        cmd(a_lat, dq_i);
    end
  end
  // read: status, id codes or array
  always @(negedge oe_n_i) begin
    if (!ce_n_i) begin
      tog = ~tog;
      sel = hv_i ? {6'h00, addr_i[1:0]} : addr_i[7:0];
      if (busy)
        rd = {1'b0, tog, err, 5'h00};
      else if (auto || hv_i)
        rd = sel == 8'h00 ? MAKER_ID : sel == 8'h01 ? DEVICE_ID :
             sel == 8'h02 ? {7'h00, prot[addr_i[16:14]]} : 8'h00;
      else
        rd = mem[addr_i];
    end
  end
  assign dq_en_o = !ce_n_i && !oe_n_i && we_n_i;
  assign dq_o = rd;
endmodule

// *** testbench/fcd_host_assertions.sv ***
// bus timing checks on the host's flash pins
// assumes binding onto fcd_host; one clock domain
module fcd_host_assertions (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_n_o,
  input wire logic oe_n_o,
  input wire logic we_n_o,
  input wire logic [16:0] addr_o,
  input wire logic [7:0] dq_out_o,
  input wire logic dq_oe_o,
  input wire logic busy_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  logic we_d_r;
  logic [2:0] wcnt_r;
  // ==========================================================
  // index of the write strobe within the current operation
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      we_d_r <= 1'b1;
      wcnt_r <= 3'h0;
    end else begin
      we_d_r <= we_n_o;
      if (!busy_o) begin
        wcnt_r <= 3'h0;
      end else if (we_n_o && !we_d_r) begin
        wcnt_r <= wcnt_r + 3'h1;
      end
    end
  end
  // ==========================================================
  // write and read strobes
  a_write_oe_high: assert property (!we_n_o |-> oe_n_o && !ce_n_o)
    else $error("write strobe without select or with oe low");
  a_drive_oe_high: assert property (dq_oe_o |-> oe_n_o)
    else $error("host drives data while oe low");
  a_we_min_width: assert property ($fell(we_n_o) |=> !we_n_o [*8])
    else $error("write strobe too short");
  a_ce_before_we: assert property ($fell(we_n_o) |-> $past(!ce_n_o))
    else $error("write strobe fell before chip select");
  a_addr_held_we: assert property (!we_n_o && $past(!we_n_o) |->
    $stable(addr_o) && $stable(dq_out_o))
    else $error("address or data moved during write strobe");
  a_data_hold_rise: assert property ($rose(we_n_o) |=>
    !ce_n_o && dq_oe_o && $stable(dq_out_o))
    else $error("data not held after write strobe rose");
  a_read_we_high: assert property (!oe_n_o |-> we_n_o && !ce_n_o)
    else $error("read without select or with write strobe");
  a_cmd_addr: assert property (!we_n_o && wcnt_r == 3'h2 |->
    addr_o[14:0] == 15'h5555 && (dq_out_o == 8'ha0 ||
    dq_out_o == 8'h90 || dq_out_o == 8'h80))
    else $error("third write not a command at the unlock address");
  a_unlock2_addr: assert property (!we_n_o && (wcnt_r == 3'h1 ||
    (wcnt_r == 3'h4 && dq_out_o != 8'hf0)) |->
    dq_out_o == 8'h55 && addr_o[14:0] == 15'h2aaa)
    else $error("second unlock wrong data or address");
endmodule
bind fcd_host fcd_host_assertions u_fcd_host_assertions (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_n_o(ce_n_o),
  .oe_n_o(oe_n_o), .we_n_o(we_n_o), .addr_o(addr_o),
  .dq_out_o(dq_out_o), .dq_oe_o(dq_oe_o), .busy_o(busy_o));

// *** testbench/flash_command_decoder_tb_top.sv ***
// testbench: host controller against a behavioural flash
// assumes short poll limit and a short embedded operation time
module flash_command_decoder_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] MAKER = 8'h5a; // arbitrary value
  localparam logic [7:0] DEVICE = 8'hc3; // arbitrary value
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic op_valid_i = 1'b0;
  fcd_pkg::fcd_op_t op_i = fcd_pkg::FCD_OP_READ;
  logic [16:0] op_addr_i = 17'h00000;
  logic [7:0] op_data_i = 8'h00;
  logic [7:0] last_r = 8'h00;
  logic [7:0] dq_in, dq_out, f_dq, rdata_o;
  logic busy_o, done_o, error_o, ce_n, oe_n, we_n, dq_oe, f_en;
  logic hv = 1'b0;
  logic fail = 1'b0;
  logic [16:0] addr;
  int failures = 0;
  int comparisons = 0;
  always #2 clk_i = ~clk_i;
  // data pins: host, else device, else a pattern that changes
  assign dq_in = dq_oe ? dq_out : (f_en ? f_dq : ~last_r);
  always @(posedge clk_i) last_r <= dq_in;
  fcd_host #(.POLL_LIMIT(20)) u_fcd_host (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .op_valid_i(op_valid_i), .op_i(op_i),
    .op_addr_i(op_addr_i), .op_data_i(op_data_i), .dq_in_i(dq_in),
    .busy_o(busy_o), .done_o(done_o), .error_o(error_o),
    .rdata_o(rdata_o), .ce_n_o(ce_n), .oe_n_o(oe_n), .we_n_o(we_n),
    .addr_o(addr), .dq_out_o(dq_out), .dq_oe_o(dq_oe));
  fcd_flash_model #(.MAKER_ID(MAKER), .DEVICE_ID(DEVICE)) u_flash (
    .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .addr_i(addr),
    .dq_i(dq_out), .hv_i(hv), .fail_i(fail), .dq_o(f_dq),
    .dq_en_o(f_en));
  // ==========================================================
  // shared tasks
  task automatic results();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic op(input fcd_pkg::fcd_op_t k, input logic [16:0] a,
                    input logic [7:0] d);
    int n;
    @(posedge clk_i);
    #1;
    op_i = k;
    op_addr_i = a;
    op_data_i = d;
    op_valid_i = 1'b1;
    @(posedge clk_i);
    #1;
    op_valid_i = 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 20000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n >= 20000) begin
      failures++;
      $display("unexpected at %0t: no done", $time);
      results();
    end
  endtask
  task automatic rd_chk(input logic [16:0] a, input logic [7:0] e);
    op(fcd_pkg::FCD_OP_READ, a, 8'h00);
    chk(rdata_o, e);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_program();
    u_flash.mem[17'h01234] = 8'h6b;
    rd_chk(17'h01234, 8'h6b);
    op(fcd_pkg::FCD_OP_PROGRAM, 17'h14321, 8'h3c);
    chk({7'h00, error_o}, 8'h00);
    rd_chk(17'h14321, 8'h3c);
  endtask
  task automatic t_protect();
    u_flash.prot[3] = 1'b1;
    op(fcd_pkg::FCD_OP_PROGRAM, 17'h0c010, 8'h00);
    rd_chk(17'h0c010, 8'hff);
    u_flash.prot[3] = 1'b0;
    op(fcd_pkg::FCD_OP_PROGRAM, 17'h0c010, 8'h00);
    rd_chk(17'h0c010, 8'h00);
  endtask
  task automatic t_autosel();
    u_flash.prot[3] = 1'b1;
    op(fcd_pkg::FCD_OP_AUTOSEL, 17'h00000, 8'h00);
    rd_chk(17'h1ab00, MAKER);
    rd_chk(17'h00301, DEVICE);
    rd_chk(17'h0c002, 8'h01);
    rd_chk(17'h10002, 8'h00);
    op(fcd_pkg::FCD_OP_RESET, 17'h00000, 8'h00);
    rd_chk(17'h01234, 8'h6b);
    hv = 1'b1;
    rd_chk(17'h00000, MAKER);
    rd_chk(17'h00001, DEVICE);
    rd_chk(17'h0c002, 8'h01);
    hv = 1'b0;
  endtask
  task automatic t_erase();
    u_flash.mem[17'h14000] = 8'h00;
    u_flash.mem[17'h00005] = 8'h00;
    op(fcd_pkg::FCD_OP_SECTOR_ERASE, 17'h14000, 8'h00);
    rd_chk(17'h14000, 8'hff);
    rd_chk(17'h00005, 8'h00);
    op(fcd_pkg::FCD_OP_CHIP_ERASE, 17'h00000, 8'h00);
    rd_chk(17'h00005, 8'hff);
  endtask
  task automatic t_error();
    fail = 1'b1;
    op(fcd_pkg::FCD_OP_PROGRAM, 17'h00100, 8'h3c);
    chk({7'h00, error_o}, 8'h01);
    fail = 1'b0;
    op(fcd_pkg::FCD_OP_RESET, 17'h00000, 8'h00);
    rd_chk(17'h00100, 8'h3c);
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    #1;
    sys_rst_i = 1'b0;
    t_program();
    t_protect();
    t_autosel();
    t_erase();
    t_error();
    results();
  end
endmodule
